// *** logic/mmu_pkg.sv ***
// Shared constants and types for the translation control block.
// Assumes a single core clock and coprocessor accesses presented one per cycle.
package mmu_pkg;
  // Coprocessor register numbers.
  localparam logic [3:0] REG_CONTROL     = 4'h1;
  localparam logic [3:0] REG_TABLE_BASE  = 4'h2;
  localparam logic [3:0] REG_DOMAIN      = 4'h3;
  localparam logic [3:0] REG_FAULT_CAUSE = 4'h5;
  localparam logic [3:0] REG_FAULT_VADDR = 4'h6;
  localparam logic [3:0] REG_TLB_MAINT   = 4'h8;
  localparam logic [3:0] REG_LOCKDOWN    = 4'hA;
  localparam logic [3:0] REG_PROCESS_ID  = 4'hD;
  // Secondary opcode selections.
  localparam logic [2:0] OP2_DATA_TLB    = 3'h0;
  localparam logic [2:0] OP2_INSTR_TLB   = 3'h1;
  localparam logic [2:0] MAINT_ALL       = 3'h0;
  localparam logic [2:0] MAINT_ONE       = 3'h1;
  // Field positions.
  localparam int CTRL_M_BIT        = 0;
  localparam int CTRL_A_BIT        = 1;
  localparam int CTRL_S_BIT        = 8;
  localparam int CTRL_R_BIT        = 9;
  localparam int TABLE_BASE_LSB    = 14;
  localparam int LOCK_BASE_LSB     = 26;
  localparam int LOCK_VICTIM_LSB   = 20;
  localparam int LOCK_PRESERVE_BIT = 0;
  localparam int FAULT_DOMAIN_LSB  = 4;
  localparam int PID_LSB           = 25;
  localparam int IDX_W             = 6;
  localparam logic [IDX_W-1:0] VICTIM_LAST = 6'h3F;
  // Reset values.
  localparam logic [31:0] REG_RESET = 32'h0000_0000;
  // Descriptor type codes.
  localparam logic [1:0] DESC_INVALID = 2'h0;
  localparam logic [1:0] DESC_COARSE  = 2'h1;
  localparam logic [1:0] DESC_SECTION = 2'h2;
  localparam logic [1:0] DESC_FINE    = 2'h3;
  localparam logic [1:0] PAGE_LARGE   = 2'h1;
  localparam logic [1:0] PAGE_SMALL   = 2'h2;
  localparam logic [1:0] PAGE_TINY    = 2'h3;
  localparam logic [1:0] DOMAIN_NO_ACCESS = 2'h0;
  // Fault type codes.
  localparam logic [3:0] FAULT_ALIGN          = 4'h1;
  localparam logic [3:0] FAULT_SECTION_XLATE  = 4'h5;
  localparam logic [3:0] FAULT_PAGE_XLATE     = 4'h7;
  localparam logic [3:0] FAULT_SECTION_DOMAIN = 4'h9;
  localparam logic [3:0] FAULT_PAGE_DOMAIN    = 4'hB;
  // Masks over address bits 31:10 kept from the physical base.
  localparam logic [21:0] MASK_SECTION = 22'h3FFC00;
  localparam logic [21:0] MASK_LARGE   = 22'h3FFFC0;
  localparam logic [21:0] MASK_SMALL   = 22'h3FFFFC;
  localparam logic [21:0] MASK_TINY    = 22'h3FFFFF;

  typedef enum logic [1:0] {MAP_SECTION, MAP_LARGE, MAP_SMALL, MAP_TINY} map_size_t;

  typedef struct packed {
    logic        preserve;
    map_size_t   size;
    logic [21:0] vbase;
    logic [21:0] pbase;
    logic [3:0]  domain;
  } tlb_entry_t;

  typedef struct packed {
    logic        valid;
    logic        write;
    logic [3:0]  num;
    logic [2:0]  op2;
    logic [31:0] wdata;
  } cp_access_t;

  function automatic logic [21:0] page_mask(input map_size_t s);
    unique case (s)
      MAP_SECTION: page_mask = MASK_SECTION;
      MAP_LARGE:   page_mask = MASK_LARGE;
      MAP_SMALL:   page_mask = MASK_SMALL;
      MAP_TINY:    page_mask = MASK_TINY;
    endcase
  endfunction
endpackage

// *** logic/mmu_tlb_array.sv ***
// Fully associative translation buffer with indexed refill and invalidation of all unpreserved entries or of address-matched ones.
// Assumes the owner picks the refill index and keeps locked entries out of it.
`timescale 1ns/1ps
module mmu_tlb_array #(
  parameter int ENTRIES = 64,
  parameter int IW      = $clog2(ENTRIES)
) (
  input  wire logic                mclk_i,
  input  wire logic                rstn_i,
  input  wire logic [31:0]         lookup_mva_i,
  output logic                     hit_o,
  output mmu_pkg::tlb_entry_t      hit_entry_o,
  input  wire logic                fill_i,
  input  wire logic [IW-1:0]       fill_idx_i,
  input  wire mmu_pkg::tlb_entry_t fill_entry_i,
  input  wire logic                inval_all_i,
  input  wire logic                inval_one_i,
  input  wire logic [31:0]         inval_mva_i
);
  mmu_pkg::tlb_entry_t    table_q [ENTRIES];
  logic [ENTRIES-1:0]     valid_q;
  logic [ENTRIES-1:0]     hit_vec;
  logic [ENTRIES-1:0]     kill_vec;

  function automatic logic covers(input mmu_pkg::tlb_entry_t e, input logic [31:0] mva);
    covers = ((e.vbase ^ mva[31:10]) & mmu_pkg::page_mask(e.size)) == 22'h0;
  endfunction

  genvar g;
  generate
    for (g = 0; g < ENTRIES; g++)
    begin : g_entry
      assign hit_vec[g]  = valid_q[g] && covers(table_q[g], lookup_mva_i);
      assign kill_vec[g] = (inval_all_i && !table_q[g].preserve) ||
                           (inval_one_i && covers(table_q[g], inval_mva_i));
    end
  endgenerate

  always_comb
  begin
    hit_o       = 1'b0;
    hit_entry_o = table_q[0];
    for (int i = ENTRIES - 1; i >= 0; i--)
    begin
      if (hit_vec[i])
      begin
        hit_o       = 1'b1;
        hit_entry_o = table_q[i];
      end
    end
  end

  // Entry contents carry no reset; only the valid bits do.
  always_ff @(posedge mclk_i)
  begin
    if (fill_i)
      table_q[fill_idx_i] <= fill_entry_i;
  end

  // An invalidate in the refill cycle loses to the refill of that entry.
  always_ff @(posedge mclk_i or negedge rstn_i)
  begin
    if (!rstn_i)
      valid_q <= '0;
    else
    begin
      valid_q <= valid_q & ~kill_vec;
      if (fill_i)
        valid_q[fill_idx_i] <= 1'b1;
    end
  end
endmodule // mmu_tlb_array

// *** logic/mmu_translation_control.sv ***
// Translation control: coprocessor registers, TLB pair and hardware table walker.
// Assumes the core holds a request until taken and memory answers each fetch once.
`timescale 1ns/1ps
module mmu_translation_control (
  input  wire logic                mclk_i,
  input  wire logic                rstn_i,
  input  wire mmu_pkg::cp_access_t cp_i,
  output logic                     cp_ack_o,
  output logic [31:0]              cp_rdata_o,
  input  wire logic                req_valid_i,
  input  wire logic                req_data_i,
  input  wire logic [31:0]         req_vaddr_i,
  output logic                     req_ready_o,
  output logic                     rsp_valid_o,
  output logic                     rsp_abort_o,
  output logic [3:0]               rsp_fault_o,
  output logic [31:0]              rsp_paddr_o,
  output logic                     mem_req_o,
  output logic [31:0]              mem_addr_o,
  input  wire logic                mem_valid_i,
  input  wire logic [31:0]         mem_rdata_i,
  output logic [1:0]               prot_scheme_o
);
  localparam int IW = mmu_pkg::IDX_W;

  typedef enum logic [1:0] {ST_IDLE, ST_L1, ST_L2, ST_FILL} walk_state_t;

  walk_state_t          state;
  walk_state_t          next_state;
  logic                 ctrl_m;
  logic                 ctrl_a;
  logic                 ctrl_s;
  logic                 ctrl_r;
  logic [17:0]          table_base;
  logic [31:0]          domain_access;
  logic [7:0]           fault_cause;
  logic [31:0]          fault_vaddr;
  logic [6:0]           process_id;
  logic [IW-1:0]        lock_base   [2];
  logic [IW-1:0]        lock_victim [2];
  logic                 lock_keep   [2];
  logic [31:0]          cur_mva;
  logic                 cur_data;
  logic [3:0]           walk_domain;
  mmu_pkg::tlb_entry_t  walk_entry;
  logic                 cp_wr;
  logic                 take;
  logic                 sel_data;
  logic [31:0]          req_mva;
  logic [31:0]          lookup_mva;
  logic                 d_hit;
  logic                 i_hit;
  mmu_pkg::tlb_entry_t  d_entry;
  mmu_pkg::tlb_entry_t  i_entry;
  logic                 hit;
  mmu_pkg::tlb_entry_t  hit_entry;
  logic                 inval_all;
  logic                 inval_one;
  logic                 fill_d;
  logic                 fill_i;
  logic [1:0]           desc_type;
  logic                 issue_l1;
  logic                 issue_l2;
  logic [31:0]          l2_addr;
  logic                 fin;
  logic                 fin_fault;
  logic [3:0]           fin_code;
  logic [3:0]           fin_domain;
  logic [31:0]          fin_paddr;
  logic                 fin_data;
  logic [31:0]          fin_mva;
  logic [31:0]          next_rdata;

  localparam int PID_LSB_W = mmu_pkg::PID_LSB;
  // Low process space is shifted up by the process identifier.
  function automatic logic [31:0] relocate(input logic [31:0] va, input logic [6:0] pid);
    relocate = (va[31:PID_LSB_W] == 7'h0) ? {pid, va[PID_LSB_W-1:0]} : va;
  endfunction

  function automatic logic [31:0] make_paddr(input mmu_pkg::tlb_entry_t e, input logic [31:0] mva);
    logic [21:0] m;
    m = mmu_pkg::page_mask(e.size);
    make_paddr = {(e.pbase & m) | (mva[31:10] & ~m), mva[9:0]};
  endfunction

  // Domain check shared by hits and fresh refills.
  function automatic logic domain_blocked(input mmu_pkg::tlb_entry_t e, input logic [31:0] dac);
    domain_blocked = dac[2*e.domain +: 2] == mmu_pkg::DOMAIN_NO_ACCESS;
  endfunction

  assign cp_wr      = cp_i.valid && cp_i.write;
  assign take       = req_valid_i && req_ready_o;
  assign req_mva    = relocate(req_vaddr_i, process_id);
  assign sel_data   = (state == ST_IDLE) ? req_data_i : cur_data;
  assign lookup_mva = (state == ST_IDLE) ? req_mva : cur_mva;
  assign hit        = sel_data ? d_hit : i_hit;
  assign hit_entry  = sel_data ? d_entry : i_entry;
  assign desc_type  = mem_rdata_i[1:0];
  assign inval_all  = cp_wr && cp_i.num == mmu_pkg::REG_TLB_MAINT && cp_i.op2 == mmu_pkg::MAINT_ALL;
  assign inval_one  = cp_wr && cp_i.num == mmu_pkg::REG_TLB_MAINT && cp_i.op2 == mmu_pkg::MAINT_ONE;
  assign fill_d     = (state == ST_FILL) && cur_data;
  assign fill_i     = (state == ST_FILL) && !cur_data;

  // Alignment faults take priority over translation; MMU off passes the relocated address untranslated.
  assign issue_l1 = take && ctrl_m && !hit && !(ctrl_a && req_data_i && req_vaddr_i[1:0] != 2'h0);
  assign issue_l2 = (state == ST_L1) && mem_valid_i &&
                    (desc_type == mmu_pkg::DESC_COARSE || desc_type == mmu_pkg::DESC_FINE);
  assign l2_addr  = (desc_type == mmu_pkg::DESC_COARSE) ? {mem_rdata_i[31:10], cur_mva[19:12], 2'b00}
                                                        : {mem_rdata_i[31:12], cur_mva[19:10], 2'b00};

  mmu_tlb_array #(.ENTRIES(1 << IW)) u_data_tlb (
    .mclk_i       (mclk_i),
    .rstn_i       (rstn_i),
    .lookup_mva_i (lookup_mva),
    .hit_o        (d_hit),
    .hit_entry_o  (d_entry),
    .fill_i       (fill_d),
    .fill_idx_i   (lock_victim[0]),
    .fill_entry_i (walk_entry),
    .inval_all_i  (inval_all),
    .inval_one_i  (inval_one),
    .inval_mva_i  (cp_i.wdata)
  );

  mmu_tlb_array #(.ENTRIES(1 << IW)) u_instr_tlb (
    .mclk_i       (mclk_i),
    .rstn_i       (rstn_i),
    .lookup_mva_i (lookup_mva),
    .hit_o        (i_hit),
    .hit_entry_o  (i_entry),
    .fill_i       (fill_i),
    .fill_idx_i   (lock_victim[1]),
    .fill_entry_i (walk_entry),
    .inval_all_i  (inval_all),
    .inval_one_i  (inval_one),
    .inval_mva_i  (cp_i.wdata)
  );

  always_comb
  begin
    next_state = state;
    unique case (state)
      ST_IDLE:
        if (issue_l1)
          next_state = ST_L1;
      ST_L1:
        if (mem_valid_i)
        begin
          if (desc_type == mmu_pkg::DESC_SECTION)
            next_state = ST_FILL;
          else if (desc_type == mmu_pkg::DESC_INVALID)
            next_state = ST_IDLE;
          else
            next_state = ST_L2;
        end
      ST_L2:
        if (mem_valid_i)
          next_state = (desc_type == mmu_pkg::DESC_INVALID) ? ST_IDLE : ST_FILL;
      ST_FILL:
        next_state = ST_IDLE;
    endcase
  end

  // Finishing condition for a translation and its outcome.
  always_comb
  begin
    fin        = 1'b0;
    fin_fault  = 1'b0;
    fin_code   = 4'h0;
    fin_domain = 4'h0;
    fin_paddr  = lookup_mva;
    fin_data   = sel_data;
    fin_mva    = lookup_mva;
    if (take && ctrl_a && req_data_i && req_vaddr_i[1:0] != 2'h0)
    begin
      fin       = 1'b1;
      fin_fault = 1'b1;
      fin_code  = mmu_pkg::FAULT_ALIGN;
    end
    else if (take && !ctrl_m)
      fin = 1'b1;
    else if (take && hit)
    begin
      fin        = 1'b1;
      fin_domain = hit_entry.domain;
      fin_paddr  = make_paddr(hit_entry, req_mva);
      if (domain_blocked(hit_entry, domain_access))
      begin
        fin_fault = 1'b1;
        fin_code  = (hit_entry.size == mmu_pkg::MAP_SECTION) ? mmu_pkg::FAULT_SECTION_DOMAIN
                                                             : mmu_pkg::FAULT_PAGE_DOMAIN;
      end
    end
    else if (state == ST_L1 && mem_valid_i && desc_type == mmu_pkg::DESC_INVALID)
    begin
      fin        = 1'b1;
      fin_fault  = 1'b1;
      fin_code   = mmu_pkg::FAULT_SECTION_XLATE;
      fin_domain = mem_rdata_i[8:5];
    end
    else if (state == ST_L2 && mem_valid_i && desc_type == mmu_pkg::DESC_INVALID)
    begin
      fin        = 1'b1;
      fin_fault  = 1'b1;
      fin_code   = mmu_pkg::FAULT_PAGE_XLATE;
      fin_domain = walk_domain;
    end
    else if (state == ST_FILL)
    begin
      fin        = 1'b1;
      fin_domain = walk_entry.domain;
      fin_paddr  = make_paddr(walk_entry, cur_mva);
      if (domain_blocked(walk_entry, domain_access))
      begin
        fin_fault = 1'b1;
        fin_code  = (walk_entry.size == mmu_pkg::MAP_SECTION) ? mmu_pkg::FAULT_SECTION_DOMAIN
                                                              : mmu_pkg::FAULT_PAGE_DOMAIN;
      end
    end
  end

  always_ff @(posedge mclk_i or negedge rstn_i)
  begin
    if (!rstn_i)
    begin
      state       <= ST_IDLE;
      req_ready_o <= 1'b0;
    end
    else
    begin
      state       <= next_state;
      req_ready_o <= next_state == ST_IDLE;
    end
  end

  always_ff @(posedge mclk_i or negedge rstn_i)
  begin
    if (!rstn_i)
    begin
      cur_mva     <= mmu_pkg::REG_RESET;
      cur_data    <= 1'b0;
      walk_domain <= 4'h0;
      walk_entry  <= '0;
    end
    else
    begin
      if (issue_l1)
      begin
        cur_mva  <= req_mva;
        cur_data <= req_data_i;
      end
      if (state == ST_L1 && mem_valid_i)
      begin
        walk_domain       <= mem_rdata_i[8:5];
        walk_entry.domain <= mem_rdata_i[8:5];
        walk_entry.vbase  <= cur_mva[31:10];
        walk_entry.pbase  <= mem_rdata_i[31:10];
        walk_entry.size   <= mmu_pkg::MAP_SECTION;
        walk_entry.preserve <= cur_data ? lock_keep[0] : lock_keep[1];
      end
      if (state == ST_L2 && mem_valid_i)
      begin
        walk_entry.pbase <= mem_rdata_i[31:10];
        unique case (desc_type)
          mmu_pkg::PAGE_LARGE: walk_entry.size <= mmu_pkg::MAP_LARGE;
          mmu_pkg::PAGE_SMALL: walk_entry.size <= mmu_pkg::MAP_SMALL;
          default:             walk_entry.size <= mmu_pkg::MAP_TINY;
        endcase
      end
    end
  end

  // A new fetch issued in the answer cycle keeps the request high.
  always_ff @(posedge mclk_i or negedge rstn_i)
  begin
    if (!rstn_i)
    begin
      mem_req_o  <= 1'b0;
      mem_addr_o <= mmu_pkg::REG_RESET;
    end
    else if (issue_l1)
    begin
      mem_req_o  <= 1'b1;
      mem_addr_o <= {table_base, req_mva[31:20], 2'b00};
    end
    else if (issue_l2)
    begin
      mem_req_o  <= 1'b1;
      mem_addr_o <= l2_addr;
    end
    else if (mem_valid_i)
      mem_req_o <= 1'b0;
  end

  always_ff @(posedge mclk_i or negedge rstn_i)
  begin
    if (!rstn_i)
    begin
      rsp_valid_o <= 1'b0;
      rsp_abort_o <= 1'b0;
      rsp_fault_o <= 4'h0;
      rsp_paddr_o <= mmu_pkg::REG_RESET;
    end
    else
    begin
      rsp_valid_o <= fin;
      if (fin)
      begin
        rsp_abort_o <= fin_fault;
        rsp_fault_o <= fin_code;
        rsp_paddr_o <= fin_paddr;
      end
    end
  end

  // Configuration registers; a write is visible to requests taken on later edges.
  always_ff @(posedge mclk_i or negedge rstn_i)
  begin
    if (!rstn_i)
    begin
      ctrl_m        <= 1'b0;
      ctrl_a        <= 1'b0;
      ctrl_s        <= 1'b0;
      ctrl_r        <= 1'b0;
      table_base    <= 18'h0;
      domain_access <= mmu_pkg::REG_RESET;
      process_id    <= 7'h0;
    end
    else if (cp_wr)
    begin
      unique case (cp_i.num)
        mmu_pkg::REG_CONTROL:
        begin
          ctrl_m <= cp_i.wdata[mmu_pkg::CTRL_M_BIT];
          ctrl_a <= cp_i.wdata[mmu_pkg::CTRL_A_BIT];
          ctrl_s <= cp_i.wdata[mmu_pkg::CTRL_S_BIT];
          ctrl_r <= cp_i.wdata[mmu_pkg::CTRL_R_BIT];
        end
        mmu_pkg::REG_TABLE_BASE: table_base <= cp_i.wdata[31:mmu_pkg::TABLE_BASE_LSB];
        mmu_pkg::REG_DOMAIN:     domain_access <= cp_i.wdata;
        mmu_pkg::REG_PROCESS_ID: process_id <= cp_i.wdata[31:mmu_pkg::PID_LSB];
        default:                 ;
      endcase
    end
  end

  // Hardware capture wins over a software write in the same cycle.
  always_ff @(posedge mclk_i or negedge rstn_i)
  begin
    if (!rstn_i)
    begin
      fault_cause <= 8'h0;
      fault_vaddr <= mmu_pkg::REG_RESET;
    end
    else
    begin
      if (fin && fin_fault)
        fault_cause <= {fin_domain, fin_code};
      else if (cp_wr && cp_i.num == mmu_pkg::REG_FAULT_CAUSE)
        fault_cause <= cp_i.wdata[7:0];
      if (fin && fin_fault && fin_data)
        fault_vaddr <= fin_mva;
      else if (cp_wr && cp_i.num == mmu_pkg::REG_FAULT_VADDR)
        fault_vaddr <= cp_i.wdata;
    end
  end

  // Lockdown pair: index 0 is the data copy, index 1 the instruction copy.
  genvar t;
  generate
    for (t = 0; t < 2; t++)
    begin : g_lock
      logic sw_sel;
      logic refill;
      assign sw_sel = cp_wr && cp_i.num == mmu_pkg::REG_LOCKDOWN &&
                      cp_i.op2 == ((t == 0) ? mmu_pkg::OP2_DATA_TLB : mmu_pkg::OP2_INSTR_TLB);
      assign refill = (t == 0) ? fill_d : fill_i;
      always_ff @(posedge mclk_i or negedge rstn_i)
      begin
        if (!rstn_i)
        begin
          lock_base[t]   <= '0;
          lock_victim[t] <= '0;
          lock_keep[t]   <= 1'b0;
        end
        else if (sw_sel)
        begin
          lock_base[t]   <= cp_i.wdata[mmu_pkg::LOCK_BASE_LSB +: IW];
          lock_victim[t] <= cp_i.wdata[mmu_pkg::LOCK_VICTIM_LSB +: IW];
          lock_keep[t]   <= cp_i.wdata[mmu_pkg::LOCK_PRESERVE_BIT];
        end
        else if (refill)
          lock_victim[t] <= (lock_victim[t] == mmu_pkg::VICTIM_LAST) ? lock_base[t]
                                                                     : lock_victim[t] + 1'b1;
      end
    end
  endgenerate

  always_comb
  begin
    next_rdata = mmu_pkg::REG_RESET;
    unique case (cp_i.num)
      mmu_pkg::REG_CONTROL:
      begin
        next_rdata[mmu_pkg::CTRL_M_BIT] = ctrl_m;
        next_rdata[mmu_pkg::CTRL_A_BIT] = ctrl_a;
        next_rdata[mmu_pkg::CTRL_S_BIT] = ctrl_s;
        next_rdata[mmu_pkg::CTRL_R_BIT] = ctrl_r;
      end
      mmu_pkg::REG_TABLE_BASE:  next_rdata = {table_base, 14'h0};
      mmu_pkg::REG_DOMAIN:      next_rdata = domain_access;
      mmu_pkg::REG_FAULT_CAUSE: next_rdata = {24'h0, fault_cause};
      mmu_pkg::REG_FAULT_VADDR: next_rdata = fault_vaddr;
      mmu_pkg::REG_PROCESS_ID:  next_rdata = {process_id, 25'h0};
      mmu_pkg::REG_LOCKDOWN:
        if (cp_i.op2 == mmu_pkg::OP2_DATA_TLB || cp_i.op2 == mmu_pkg::OP2_INSTR_TLB)
        begin
          next_rdata[mmu_pkg::LOCK_BASE_LSB +: IW]   = lock_base[cp_i.op2[0]];
          next_rdata[mmu_pkg::LOCK_VICTIM_LSB +: IW] = lock_victim[cp_i.op2[0]];
          next_rdata[mmu_pkg::LOCK_PRESERVE_BIT]     = lock_keep[cp_i.op2[0]];
        end
      default:                  next_rdata = mmu_pkg::REG_RESET;
    endcase
  end

  always_ff @(posedge mclk_i or negedge rstn_i)
  begin
    if (!rstn_i)
    begin
      cp_ack_o      <= 1'b0;
      cp_rdata_o    <= mmu_pkg::REG_RESET;
      prot_scheme_o <= 2'h0;
    end
    else
    begin
      cp_ack_o      <= cp_i.valid;
      prot_scheme_o <= {ctrl_s, ctrl_r};
      if (cp_i.valid && !cp_i.write)
        cp_rdata_o <= next_rdata;
    end
  end
endmodule // mmu_translation_control

// *** sim/mmu_translation_control_props.sv ***
// Port checker for the translation control block.
// Assumes it is bound to the top module and sees only its ports.
`timescale 1ns/1ps
module mmu_translation_control_props (
  input wire logic                mclk_i,
  input wire logic                rstn_i,
  input wire mmu_pkg::cp_access_t cp_i,
  input wire logic                cp_ack_o,
  input wire logic [31:0]         cp_rdata_o,
  input wire logic                req_valid_i,
  input wire logic [31:0]         req_vaddr_i,
  input wire logic                req_ready_o,
  input wire logic                rsp_valid_o,
  input wire logic                mem_req_o,
  input wire logic [31:0]         mem_addr_o,
  input wire logic                mem_valid_i
);
  default clocking @(posedge mclk_i); endclocking
  default disable iff (!rstn_i);
  logic [31:0] taken_va;
  always_ff @(posedge mclk_i) if (req_valid_i && req_ready_o) taken_va <= req_vaddr_i;
  sequence s_rd(n); cp_i.valid && !cp_i.write && cp_i.num == n; endsequence
  sequence s_l1_done; mem_valid_i ##1 (!mem_req_o && !rsp_valid_o); endsequence
  AST_CP_ACK: assert property (cp_i.valid |=> cp_ack_o)
    else $error("access not acknowledged");
  AST_CP_QUIET: assert property (!cp_i.valid |=> !cp_ack_o)
    else $error("stray acknowledge");
  AST_BASE_LOW: assert property (s_rd(mmu_pkg::REG_TABLE_BASE) |=> cp_rdata_o[13:0] == 14'h0000)
    else $error("table base low bits set");
  AST_MAINT_RD: assert property (s_rd(mmu_pkg::REG_TLB_MAINT) |=> cp_rdata_o == 32'h0000_0000)
    else $error("maintenance read not zero");
  AST_L1_ADDR: assert property ($rose(mem_req_o) |-> mem_addr_o[13:0] == {taken_va[31:20], 2'h0})
    else $error("level one address wrong");
  AST_WALK_BUSY: assert property ($rose(mem_req_o) |-> !req_ready_o)
    else $error("ready during walk");
  AST_MEM_HOLD: assert property (mem_req_o && !mem_valid_i |=> mem_req_o && $stable(mem_addr_o))
    else $error("fetch dropped");
  AST_L1_FINISH: assert property (s_l1_done |=> rsp_valid_o)
    else $error("section walk not finished");
  AST_RSP_READY: assert property (rsp_valid_o |-> req_ready_o)
    else $error("answer without ready");
endmodule // mmu_translation_control_props
bind mmu_translation_control mmu_translation_control_props i_props (.mclk_i(mclk_i), .rstn_i(rstn_i),
  .cp_i(cp_i), .cp_ack_o(cp_ack_o), .cp_rdata_o(cp_rdata_o), .req_valid_i(req_valid_i),
  .req_vaddr_i(req_vaddr_i), .req_ready_o(req_ready_o), .rsp_valid_o(rsp_valid_o),
  .mem_req_o(mem_req_o), .mem_addr_o(mem_addr_o), .mem_valid_i(mem_valid_i));

// *** sim/mmu_desc_memory.sv ***
// Descriptor memory model answering table walk fetches.
// Assumes one fetch at a time; the bench loads words before a walk.
`timescale 1ns/1ps
module mmu_desc_memory (
  input  wire logic        mclk_i,
  input  wire logic        rstn_i,
  input  wire logic        mem_req_i,
  input  wire logic [31:0] mem_addr_i,
  input  wire logic [3:0]  lat_i,
  output logic             mem_valid_o,
  output logic [31:0]      mem_rdata_o
);
  logic [31:0] words [logic [31:0]];
  logic [3:0]  cnt;
  // Data toggles outside the answer cycle so a late sample never matches.
  always @(posedge mclk_i or negedge rstn_i)
    if (!rstn_i)
      {mem_valid_o, mem_rdata_o, cnt} <= '0;
    else
    begin
      {mem_valid_o, mem_rdata_o, cnt} <= {1'b0, ~mem_rdata_o, 4'h0};
      if (mem_req_i && !mem_valid_o && cnt >= lat_i)
        {mem_valid_o, mem_rdata_o} <= {1'b1, words[mem_addr_i]};
      else if (mem_req_i && !mem_valid_o)
        cnt <= cnt + 4'h1;
    end
endmodule // mmu_desc_memory

// *** sim/mmu_translation_control_test.sv ***
// Bench: coprocessor accesses and table walks with a memory model.
// Assumes the checker is bound to the design.
`timescale 1ns/1ps
module mmu_translation_control_test;
  logic                mclk_i = 1'b0;
  logic                rstn_i = 1'b0;
  mmu_pkg::cp_access_t cp = '0;
  logic                rq = 1'b0, rq_d = 1'b0, mq = 1'b0, ack, rv, ab, mreq, mval;
  logic [31:0]         va = '0, rd, pa, maddr, mdat;
  logic [3:0]          lat = 4'h0, flt;
  logic [1:0]          prot;
  int                  fail_count = 0, cmp_count = 0, walks = 0;
  mmu_translation_control i_dut (.mclk_i(mclk_i), .rstn_i(rstn_i), .cp_i(cp), .cp_ack_o(ack), .cp_rdata_o(rd),
    .req_valid_i(rq), .req_data_i(rq_d), .req_vaddr_i(va), .req_ready_o(), .rsp_valid_o(rv), .rsp_abort_o(ab),
    .rsp_fault_o(flt), .rsp_paddr_o(pa), .mem_req_o(mreq), .mem_addr_o(maddr), .mem_valid_i(mval),
    .mem_rdata_i(mdat), .prot_scheme_o(prot));
  mmu_desc_memory i_mem (.mclk_i(mclk_i), .rstn_i(rstn_i), .mem_req_i(mreq), .mem_addr_i(maddr), .lat_i(lat),
    .mem_valid_o(mval), .mem_rdata_o(mdat));
  initial forever #5 mclk_i = ~mclk_i;
  always @(posedge mclk_i) mq <= mreq;
  always @(posedge mclk_i) if (mreq && !mq) walks++;
  task automatic print_verdict;
    $display("compares %0d mismatches %0d", cmp_count, fail_count);
    if (fail_count == 0 && cmp_count > 0)
      $display("STATUS OK");
    else
      $display("STATUS NOT OK");
    $finish;
  endtask
  task automatic chk(input logic [31:0] g, input logic [31:0] e);
    cmp_count++;
    if (g !== e)
    begin
      fail_count++;
      $display("mismatch t=%0t got=%h exp=%h", $time, g, e);
    end
  endtask
  task automatic acc(input logic w, input logic [3:0] n, input logic [2:0] o, input logic [31:0] d);
    int i;
    i = 0;
    @(posedge mclk_i) cp <= '{1'b1, w, n, o, d};
    @(posedge mclk_i) cp.valid <= 1'b0;
    do @(negedge mclk_i); while (ack !== 1'b1 && ++i < 3);
    fail_count += int'(i == 3);
    if (i == 3) print_verdict;
  endtask
  task automatic rdc(input logic [3:0] n, input logic [2:0] o, input logic [31:0] e);
    acc(1'b0, n, o, 32'h0000_0000);
    chk(rd, e);
  endtask
  // Expects either a physical address or, on abort, the fault code in e.
  task automatic xl(input logic d, input logic [31:0] v, input logic a, input logic [31:0] e, input int wk);
    int i, w0;
    i = 0;
    w0 = walks;
    @(posedge mclk_i) {rq, rq_d, va} <= {1'b1, d, v};
    @(posedge mclk_i) rq <= 1'b0;
    do @(negedge mclk_i); while (rv !== 1'b1 && ++i < 40);
    fail_count += int'(i == 40);
    if (i == 40) print_verdict;
    chk({31'h0, ab}, {31'h0, a});
    chk(a ? {28'h0, flt} : pa, e);
    chk(walks - w0, wk);
  endtask
  initial
  begin
    i_mem.words[32'h0004_448C] = 32'h8760_0002;
    i_mem.words[32'h0004_4800] = 32'h0009_0001;
    i_mem.words[32'h0009_0004] = 32'h5550_1002;
    i_mem.words[32'h0009_0048] = 32'h6660_0001;
    i_mem.words[32'h0004_4C00] = 32'h000A_0003;
    i_mem.words[32'h000A_000C] = 32'h7770_0403;
    i_mem.words[32'h0004_5000] = 32'h0000_0000;
    i_mem.words[32'h0004_5400] = 32'h0000_0000;
    i_mem.words[32'h0004_5800] = 32'h8800_0022;
    repeat (20) @(posedge mclk_i);
    rstn_i <= 1'b1;
    rdc(4'h1, 3'h0, 32'h0000_0000);
    acc(1'b1, 4'h2, 3'h0, 32'h0004_7FFF);
    rdc(4'h2, 3'h0, 32'h0004_4000);
    acc(1'b1, 4'h3, 3'h0, 32'h5555_5551);
    rdc(4'h3, 3'h0, 32'h5555_5551);
    rdc(4'h8, 3'h0, 32'h0000_0000);
    acc(1'b1, 4'hA, 3'h1, 32'h0C10_0001);
    rdc(4'hA, 3'h1, 32'h0C10_0001);
    rdc(4'hA, 3'h0, 32'h0000_0000);
    acc(1'b1, 4'h1, 3'h0, 32'h0000_0103);
    rdc(4'h1, 3'h0, 32'h0000_0103);
    chk({30'h0, prot}, 32'h0000_0002);
    xl(1'b1, 32'h1234_5678, 1'b0, 32'h8764_5678, 1);
    xl(1'b1, 32'h1234_5678, 1'b0, 32'h8764_5678, 0);
    lat <= 4'h5;
    xl(1'b1, 32'h2000_1400, 1'b0, 32'h5550_1400, 1);
    xl(1'b1, 32'h2001_2344, 1'b0, 32'h6660_2344, 1);
    xl(1'b0, 32'h3000_0C00, 1'b0, 32'h7770_0400, 1);
    rdc(4'hA, 3'h1, 32'h0C20_0001);
    xl(1'b1, 32'h4000_0000, 1'b1, 32'h0000_0005, 1);
    rdc(4'h5, 3'h0, 32'h0000_0005);
    rdc(4'h6, 3'h0, 32'h4000_0000);
    xl(1'b0, 32'h5000_0000, 1'b1, 32'h0000_0005, 1);
    rdc(4'h6, 3'h0, 32'h4000_0000);
    xl(1'b1, 32'h6000_0000, 1'b1, 32'h0000_0009, 1);
    rdc(4'h5, 3'h0, 32'h0000_0019);
    xl(1'b1, 32'h1234_5679, 1'b1, 32'h0000_0001, 0);
    acc(1'b1, 4'h8, 3'h0, 32'h0000_0000);
    xl(1'b0, 32'h3000_0C00, 1'b0, 32'h7770_0400, 0);
    xl(1'b1, 32'h1234_5678, 1'b0, 32'h8764_5678, 1);
    acc(1'b1, 4'h8, 3'h1, 32'h1234_5000);
    xl(1'b1, 32'h1234_5678, 1'b0, 32'h8764_5678, 1);
    acc(1'b1, 4'hD, 3'h0, 32'h1200_0000);
    xl(1'b1, 32'h0034_5678, 1'b0, 32'h8764_5678, 0);
    print_verdict;
  end
endmodule // mmu_translation_control_test
